// >>> design/swsw_pkg.sv
`default_nettype none

package swsw_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS   = 4;
   localparam int unsigned UV_TIME_NS      = 2000;
   localparam int unsigned UV_CYCLES       = (UV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0]  UV_COUNT_MAX    = 10'(UV_CYCLES);

   // Command byte decode
   localparam logic [5:0]  STATUS_ADDR     = 6'h13;
   localparam logic [1:0]  OP_READ         = 2'h1;
   localparam logic [1:0]  OP_READ_CLEAR   = 2'h2;

   // Field positions of the status word
   localparam int unsigned BIT_TSD         = 15;
   localparam int unsigned BIT_TW          = 14;
   localparam int unsigned WAKE_HI         = 13;
   localparam int unsigned WAKE_LO         = 12;
   localparam int unsigned BIT_RFAIL       = 11;
   localparam int unsigned RST_HI          = 10;
   localparam int unsigned RST_LO          = 8;
   localparam int unsigned MISS_HI         = 7;
   localparam int unsigned MISS_LO         = 4;
   localparam int unsigned BIT_FWD         = 3;
   localparam int unsigned BIT_FHS         = 2;
   localparam int unsigned PROG_HI         = 1;
   localparam int unsigned PROG_LO         = 0;

   // Wake origin codes
   localparam logic [1:0]  WAKE_NONE       = 2'h0;
   localparam logic [1:0]  WAKE_MAIN_STBY  = 2'h1;
   localparam logic [1:0]  WAKE_BAT_STBY   = 2'h2;
   localparam logic [1:0]  WAKE_FLASH      = 2'h3;

   // Counter limits and reset values
   localparam logic [2:0]  RESTART_LIMIT   = 3'h7;
   localparam logic [3:0]  MISS_LIMIT      = 4'hf;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam logic [7:0]  BYTE_RESET      = 8'h00;
   localparam int unsigned PIN_W           = 5;

   typedef enum logic [1:0] {
      RSP_IDLE  = 2'b00,
      RSP_UPPER = 2'b01,
      RSP_LOWER = 2'b11
   } swsw_rsp_e;

   typedef struct packed {
      logic       valid;
      logic [1:0] op;
      logic [5:0] addr;
   } swsw_cmd_s;

   typedef struct packed {
      logic tsd;
      logic tw;
      logic reg_low;
      logic second_level_thermal_shutdown;
      logic reg_short;
   } swsw_pins_s;

   typedef struct packed {
      logic       trigger_ok;
      logic       trigger_missed;
      logic [1:0] progress;
   } swsw_wd_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } swsw_rsp_s;

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [PIN_W-1:0] out;
   } swsw_sync_s;

   typedef struct packed {
      swsw_rsp_e  st;
      logic [15:0] snap;
      swsw_rsp_s  rsp;
      logic       tsd_f;
      logic       tw_f;
      logic [1:0] wake;
      logic       rfail;
      logic [2:0] rst_cnt;
      logic [3:0] miss_cnt;
      logic       fwd;
      logic       fhs;
      logic [1:0] prog;
      logic [9:0] uv_cnt;
      swsw_pins_s pins_q;
      logic       standby_req;
      logic [15:0] word;
   } swsw_state_s;

endpackage

`default_nettype wire

// >>> design/swsw_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; output moves only when stages two and three agree
module swsw_sync (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic [swsw_pkg::PIN_W-1:0] pin_async,
   output logic      [swsw_pkg::PIN_W-1:0] pin_sync
);
   import swsw_pkg::*;

   swsw_sync_s r_ff;
   swsw_sync_s nxt_r;

   always_comb begin
      nxt_r    = r_ff;
      nxt_r.s1 = pin_async;
      nxt_r.s2 = r_ff.s1;
      nxt_r.s3 = r_ff.s2;
      for (int i = 0; i < PIN_W; i++) begin
         if (r_ff.s2[i] == r_ff.s3[i]) begin
            nxt_r.out[i] = r_ff.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign pin_sync = r_ff.out;

endmodule

`default_nettype wire

// >>> design/swsw_status.sv
// What this block does
// - Thermal shutdown bit 15 and warning bit 14 latch until read-and-clear.
// - Bits 13:12 record wake origin: 01 main standby, 10 battery, 11 flash.
// - Wake origin holds until read-and-clear, then takes the current state.
// - Bit 11 latches when main regulator stays under 2 V beyond 2 us.
// - Bits 10:8 count restarts from second thermal shutdown; seventh forces battery standby.
// - Bits 7:4 count missed triggers; 15 forces standby; good trigger zeroes it.
// - Bit 3 latches when watchdog errors forced standby.
// - Bit 2 latches on thermal or short forced standby; both clear on read-and-clear.
// - Bits 1:0 show live watchdog window progress; 00 means first third.
// - Read-and-clear never touches the progress field.
// - Address 010011 selects this word; upper byte returned first, then lower.
`timescale 1ns/1ps
`default_nettype none

module swsw_status (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire swsw_pkg::swsw_cmd_s  cmd,
   input  wire swsw_pkg::swsw_pins_s pins_async,
   input  wire swsw_pkg::swsw_wd_s   wd,
   input  wire logic                 wake_evt,
   input  wire logic [1:0]           cur_state,
   output var swsw_pkg::swsw_rsp_s   rsp,
   output logic [15:0]               status_word,
   output logic                      battery_standby_req
);
   import swsw_pkg::*;

   swsw_state_s r_ff;
   swsw_state_s nxt_r;
   swsw_pins_s  pins;
   logic        take;
   logic        clr;
   logic        second_level_thermal_shutdown_rise;
   logic        short_rise;
   logic        miss_force;
   logic        heat_force;

   swsw_sync u_sync (
      .clk       (clk),
      .rstn      (rstn),
      .pin_async (pins_async),
      .pin_sync  (pins)
   );

   // Request decode
   always_comb begin
      take = cmd.valid && (r_ff.st == RSP_IDLE) && (cmd.addr == STATUS_ADDR) &&
             ((cmd.op == OP_READ) || (cmd.op == OP_READ_CLEAR));
      clr  = take && (cmd.op == OP_READ_CLEAR);
   end

   // Event detection
   always_comb begin
      second_level_thermal_shutdown_rise  = pins.second_level_thermal_shutdown && !r_ff.pins_q.second_level_thermal_shutdown;
      short_rise = pins.reg_short && !r_ff.pins_q.reg_short;
      miss_force = wd.trigger_missed && !wd.trigger_ok &&
                   (r_ff.miss_cnt == MISS_LIMIT - 4'h1);
      heat_force = (second_level_thermal_shutdown_rise && (r_ff.rst_cnt == RESTART_LIMIT - 3'h1)) ||
                   short_rise;
   end

   always_comb begin
      nxt_r        = r_ff;
      nxt_r.pins_q = pins;

      // Thermal flags; a set in the clearing cycle wins
      nxt_r.tsd_f = (r_ff.tsd_f && !clr) || pins.tsd;
      nxt_r.tw_f  = (r_ff.tw_f && !clr) || pins.tw;

      // Wake origin
      if (clr) begin
         nxt_r.wake = cur_state;
      end else if (wake_evt && (r_ff.wake == WAKE_NONE)) begin
         nxt_r.wake = cur_state;
      end

      // Undervoltage filter
      if (!pins.reg_low) begin
         nxt_r.uv_cnt = '0;
      end else if (r_ff.uv_cnt != UV_COUNT_MAX) begin
         nxt_r.uv_cnt = r_ff.uv_cnt + 10'h1;
      end
      nxt_r.rfail = (r_ff.rfail && !clr) ||
                    (pins.reg_low && (r_ff.uv_cnt == UV_COUNT_MAX));

      // Restart counter, software cannot clear it
      if (second_level_thermal_shutdown_rise && (r_ff.rst_cnt != RESTART_LIMIT)) begin
         nxt_r.rst_cnt = r_ff.rst_cnt + 3'h1;
      end

      // Missed trigger counter
      if (wd.trigger_ok) begin
         nxt_r.miss_cnt = '0;
      end else if (wd.trigger_missed && (r_ff.miss_cnt != MISS_LIMIT)) begin
         nxt_r.miss_cnt = r_ff.miss_cnt + 4'h1;
      end

      // Forced standby flags
      nxt_r.fwd = (r_ff.fwd && !clr) || miss_force;
      nxt_r.fhs = (r_ff.fhs && !clr) || heat_force;
      nxt_r.standby_req = miss_force || heat_force;

      // Progress follows the counter only, never the clear
      nxt_r.prog = wd.progress;

      nxt_r.word = {nxt_r.tsd_f, nxt_r.tw_f, nxt_r.wake, nxt_r.rfail,
                    nxt_r.rst_cnt, nxt_r.miss_cnt, nxt_r.fwd, nxt_r.fhs,
                    nxt_r.prog};

      // Two-byte answer, upper byte first
      case (r_ff.st)
         RSP_IDLE: begin
            nxt_r.rsp.valid = 1'b0;
            if (take) begin
               nxt_r.snap      = r_ff.word;
               nxt_r.rsp.valid = 1'b1;
               nxt_r.rsp.data  = r_ff.word[15:8];
               nxt_r.st        = RSP_UPPER;
            end
         end
         RSP_UPPER: begin
            nxt_r.rsp.valid = 1'b1;
            nxt_r.rsp.data  = r_ff.snap[7:0];
            nxt_r.st        = RSP_LOWER;
         end
         RSP_LOWER: begin
            nxt_r.rsp.valid = 1'b0;
            nxt_r.rsp.data  = BYTE_RESET;
            nxt_r.st        = RSP_IDLE;
         end
         default: begin
            nxt_r.rsp.valid = 1'b0;
            nxt_r.st        = RSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_ff      <= '0;
         r_ff.st   <= RSP_IDLE;
         r_ff.word <= STATUS_RESET;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign rsp                 = r_ff.rsp;
   assign status_word         = r_ff.word;
   assign battery_standby_req = r_ff.standby_req;

   // Checks

   tsd_latch_a: assert property (@(posedge clk) disable iff (!rstn)
      (status_word[BIT_TSD] && !clr) |=> status_word[BIT_TSD])
      else $error("thermal shutdown flag dropped without clear");

   tw_set_a: assert property (@(posedge clk) disable iff (!rstn)
      pins.tw |=> status_word[BIT_TW])
      else $error("thermal warning not latched");

   wake_record_a: assert property (@(posedge clk) disable iff (!rstn)
      (wake_evt && !clr && status_word[WAKE_HI:WAKE_LO] == WAKE_NONE)
      |=> status_word[WAKE_HI:WAKE_LO] == $past(cur_state))
      else $error("wake origin not recorded");

   wake_update_a: assert property (@(posedge clk) disable iff (!rstn)
      clr |=> status_word[WAKE_HI:WAKE_LO] == $past(cur_state))
      else $error("wake origin not refreshed after clear");

   wake_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (!clr && status_word[WAKE_HI:WAKE_LO] != WAKE_NONE)
      |=> $stable(status_word[WAKE_HI:WAKE_LO]))
      else $error("wake origin changed without clear");

   uv_filter_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(status_word[BIT_RFAIL]) |-> r_ff.uv_cnt == UV_COUNT_MAX)
      else $error("regulator fail set before filter time");

   restart_keep_a: assert property (@(posedge clk) disable iff (!rstn)
      (status_word[RST_HI:RST_LO] == RESTART_LIMIT) |=>
      (status_word[RST_HI:RST_LO] == RESTART_LIMIT))
      else $error("restart counter left saturation");

   restart_force_a: assert property (@(posedge clk) disable iff (!rstn)
      (second_level_thermal_shutdown_rise && r_ff.rst_cnt == 3'h6) |=> battery_standby_req ##0
      status_word[BIT_FHS] ##0 status_word[RST_HI:RST_LO] == RESTART_LIMIT)
      else $error("seventh restart did not force standby");

   miss_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      wd.trigger_ok |=> status_word[MISS_HI:MISS_LO] == 4'h0)
      else $error("good trigger did not zero miss count");

   miss_step_a: assert property (@(posedge clk) disable iff (!rstn)
      (wd.trigger_missed && !wd.trigger_ok && r_ff.miss_cnt < 4'he)
      |=> status_word[MISS_HI:MISS_LO] == $past(r_ff.miss_cnt) + 4'h1)
      else $error("miss count did not advance");

   wd_force_a: assert property (@(posedge clk) disable iff (!rstn)
      miss_force |=> battery_standby_req && status_word[BIT_FWD] &&
      status_word[MISS_HI:MISS_LO] == MISS_LIMIT)
      else $error("fifteenth miss did not force standby");

   heat_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      (clr && !heat_force && !miss_force) |=>
      !status_word[BIT_FHS] && !status_word[BIT_FWD])
      else $error("forced standby flags survived clear");

   prog_live_a: assert property (@(posedge clk) disable iff (!rstn)
      ##2 status_word[PROG_HI:PROG_LO] == $past(wd.progress, 1))
      else $error("progress field not live");

   prog_noclr_a: assert property (@(posedge clk) disable iff (!rstn)
      clr ##1 1'b1 |=> status_word[PROG_HI:PROG_LO] == $past(wd.progress, 1))
      else $error("clear disturbed progress field");

   byte_order_a: assert property (@(posedge clk) disable iff (!rstn)
      take |=> (rsp.valid && rsp.data == $past(status_word[15:8]))
      ##1 (rsp.valid && rsp.data == $past(status_word[7:0], 2)) ##1 !rsp.valid)
      else $error("status word bytes out of order");

endmodule

`default_nettype wire

// >>> verif/swsw_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the command port: one request, then the two answer bytes
module swsw_host (
   input  wire logic                clk,
   input  wire swsw_pkg::swsw_rsp_s rsp,
   output var  swsw_pkg::swsw_cmd_s cmd
);
   import swsw_pkg::*;

   initial cmd = '0;

   task automatic xfer(input logic [1:0] op, input logic [5:0] addr,
                       output logic [15:0] word, output logic got);
      int n;
      word = '0;
      got = 1'b0;
      n = 0;
      // Request stands until the first answer byte shows it was taken, for at most four cycles
      cmd = '{valid: 1'b1, op: op, addr: addr};
      while (!got && n < 4) begin
         @(posedge clk);
         #1;
         n++;
         if (rsp.valid === 1'b1) begin
            word[15:8] = rsp.data;
            got = 1'b1;
         end
      end
      // Released fields carry a changed pattern, not the old request
      cmd = '{valid: 1'b0, op: ~op, addr: ~addr};
      if (got) begin
         @(posedge clk);
         #1;
         if (rsp.valid === 1'b1) word[7:0] = rsp.data;
         else got = 1'b0;
      end
      // Let the answer state machine return to idle
      @(posedge clk);
      #1;
   endtask
endmodule

`default_nettype wire

// >>> verif/swsw_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

module swsw_status_tb;
   import swsw_pkg::*;

   logic       clk;
   logic       rstn;
   swsw_cmd_s  cmd;
   swsw_pins_s pins;
   swsw_wd_s   wd;
   logic       wake_evt;
   logic [1:0] cur_state;
   swsw_rsp_s  rsp;
   logic [15:0] status_word;
   logic       battery_standby_req;
   logic [15:0] w;
   logic       got;
   int         num_errors = 0;
   int         num_checks = 0;
   int         n_sb = 0;
   int         cycles = 0;

   swsw_status u_dut (.clk(clk), .rstn(rstn), .cmd(cmd), .pins_async(pins), .wd(wd),
                      .wake_evt(wake_evt), .cur_state(cur_state), .rsp(rsp),
                      .status_word(status_word), .battery_standby_req(battery_standby_req));
   swsw_host u_host (.clk(clk), .rsp(rsp), .cmd(cmd));

   always #2 clk = ~clk;

   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(negedge clk) begin
      cycles++;
      if (battery_standby_req === 1'b1) n_sb++;
      if (cycles == 6000) begin
         num_errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] mask, input logic [15:0] exp);
      num_checks++;
      if ((seen & mask) !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h mask %h expected %h", $time, seen, mask, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [1:0] op);
      u_host.xfer(op, STATUS_ADDR, w, got);
      chk({15'h0, got}, 16'h0001, 16'h0001);
   endtask

   task automatic miss(input int n);
      repeat (n) begin
         wd.trigger_missed = 1'b1;
         step(1);
         wd.trigger_missed = 1'b0;
         step(1);
      end
   endtask

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      pins = '0;
      wd = '0;
      wake_evt = 1'b0;
      cur_state = 2'h0;
      step(12);
      rstn = 1'b1;
      step(2);
      rd(OP_READ);
      chk(w, 16'hffff, STATUS_RESET);
      pins.tsd = 1'b1;
      pins.tw = 1'b1;
      step(8);
      pins = '0;
      step(8);
      rd(OP_READ); chk(w, 16'hc000, 16'hc000);
      rd(OP_READ_CLEAR); chk(w, 16'hc000, 16'hc000);
      rd(OP_READ); chk(w, 16'hc000, 16'h0000);
      // Second wake must not overwrite the first origin
      cur_state = WAKE_MAIN_STBY;
      wake_evt = 1'b1;
      step(1);
      wake_evt = 1'b0;
      cur_state = WAKE_BAT_STBY;
      step(1);
      wake_evt = 1'b1;
      step(1);
      wake_evt = 1'b0;
      step(2);
      rd(OP_READ_CLEAR); chk(w, 16'h3000, 16'h1000);
      cur_state = WAKE_FLASH;
      rd(OP_READ_CLEAR); chk(w, 16'h3000, 16'h2000);
      rd(OP_READ); chk(w, 16'h3000, 16'h3000);
      // Undervoltage well under and just over the filter time
      pins.reg_low = 1'b1;
      step(400);
      pins.reg_low = 1'b0;
      step(8);
      rd(OP_READ_CLEAR); chk(w, 16'h0800, 16'h0000);
      pins.reg_low = 1'b1;
      step(520);
      pins.reg_low = 1'b0;
      step(8);
      rd(OP_READ_CLEAR); chk(w, 16'h0800, 16'h0800);
      rd(OP_READ); chk(w, 16'h0800, 16'h0000);
      miss(14);
      rd(OP_READ); chk(w, 16'h00f8, 16'h00e0);
      chk(16'(n_sb), 16'hffff, 16'h0000);
      wd.trigger_ok = 1'b1;
      step(1);
      wd.trigger_ok = 1'b0;
      step(2);
      rd(OP_READ); chk(w, 16'h00f0, 16'h0000);
      miss(15);
      step(2);
      chk(16'(n_sb), 16'hffff, 16'h0001);
      rd(OP_READ_CLEAR); chk(w, 16'h00f8, 16'h00f8);
      rd(OP_READ); chk(w, 16'h00f8, 16'h00f0);
      for (int i = 1; i <= 7; i++) begin
         pins.second_level_thermal_shutdown = 1'b1;
         step(8);
         pins.second_level_thermal_shutdown = 1'b0;
         step(8);
         rd(OP_READ); chk(w, 16'h0704, {5'h0, 3'(i), 5'h0, i == 7, 2'h0});
      end
      chk(16'(n_sb), 16'hffff, 16'h0002);
      rd(OP_READ_CLEAR);
      rd(OP_READ); chk(w, 16'h0704, 16'h0700);
      pins.reg_short = 1'b1;
      step(8);
      pins.reg_short = 1'b0;
      step(8);
      rd(OP_READ); chk(w, 16'h0004, 16'h0004);
      for (int p = 0; p < 4; p++) begin
         wd.progress = 2'(p);
         step(4);
         rd(OP_READ_CLEAR); chk(w, 16'h0003, 16'(p));
         rd(OP_READ); chk(w, 16'h0003, 16'(p));
      end
      u_host.xfer(OP_READ, 6'h12, w, got); chk({15'h0, got}, 16'h0001, 16'h0000);
      u_host.xfer(2'h3, STATUS_ADDR, w, got); chk({15'h0, got}, 16'h0001, 16'h0000);
      print_verdict();
   end
endmodule

`default_nettype wire
